// ==== design/fdchr_pkg.sv ====
// package for the floppy controller host register block
// assumes one 200 mhz clock and an ahb-lite slave interface to software
package fdchr_pkg;
	// register indices (byte offset is index times four)
	localparam logic [7:0] fdchr_idx_mon_a = 8'h00;
	localparam logic [7:0] fdchr_idx_mon_b = 8'h01;
	localparam logic [7:0] fdchr_idx_motor = 8'h02;
	localparam logic [7:0] fdchr_idx_tape = 8'h03;
	localparam logic [7:0] fdchr_idx_status = 8'h04;
	localparam logic [7:0] fdchr_idx_fifo = 8'h05;
	localparam logic [7:0] fdchr_idx_input = 8'h07;
	localparam logic [7:0] fdchr_idx_mode = 8'h08;
	localparam logic [7:0] fdchr_idx_cfg = 8'h09;
	localparam logic [7:0] fdchr_idx_pins = 8'h0a;
	// command codes, relative seek mask and invalid command status byte
	localparam logic [7:0] fdchr_cmd_seek = 8'h0f;
	localparam logic [7:0] fdchr_cmd_dump = 8'h0e;
	localparam logic [7:0] fdchr_cmd_sense = 8'h04;
	localparam logic [7:0] fdchr_cmd_config = 8'h13;
	localparam logic [7:0] fdchr_cmd_rseek_m = 8'hbf;
	localparam logic [7:0] fdchr_cmd_rseek = 8'h8f;
	localparam logic [7:0] fdchr_cmd_perp = 8'h12;
	localparam logic [6:0] fdchr_cmd_lock = 7'h14;
	localparam logic [7:0] fdchr_st0_invalid = 8'h80;
	// reset values and dump result length
	localparam logic [7:0] fdchr_rst_byte = 8'h00;
	localparam logic [3:0] fdchr_rst_thr = 4'h0;
	localparam int fdchr_dump_len = 10;
	// htrans and hsize codes
	localparam logic [1:0] fdchr_htrans_nonseq = 2'b10;
	localparam logic [2:0] fdchr_hsize_word = 3'b010;

	typedef enum logic [3:0] {
		fdchr_idle = 4'b0001,
		fdchr_param = 4'b0010,
		fdchr_result = 4'b0100,
		fdchr_exec = 4'b1000
	} fdchr_state_t;

	// drive-side pin levels, packed
	typedef struct packed {
		logic irq;
		logic dma_request_out;
		logic second_drive_absent;
		logic track_zero_in;
		logic index_in;
		logic write_protect_in;
		logic read_data_in;
		logic write_bitstream_out;
		logic write_gate_out;
		logic disk_change_in;
	} fdchr_pins_t;

	// config-space values
	typedef struct packed {
		logic three_mode_enable;
		logic [7:0] ld0_config_f1;
		logic [7:0] ld0_config_f2;
	} fdchr_cfg_t;
endpackage

// ==== design/fdchr_top.sv ====
// floppy controller host register bank with command phase decoder
// assumes ahb-lite master with single word transfers, synchronous pin inputs
`timescale 1ns/1ps
module fdchr_top import fdchr_pkg::*; (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic master_reset_pin,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire fdchr_pins_t pins,
	input wire fdchr_cfg_t cfg,
	output logic [7:0] motor_select_ff,
	output logic [1:0] data_rate_ff,
	output logic step_out_ff,
	output logic step_dir_ff,
	output logic head_side_ff
);

	////////////////////////////////////////////////////////////////////////
	// bus address phase capture

	logic wr_pend_ff;
	logic [7:0] wr_idx_ff;
	logic rd_pend_ff;
	logic [7:0] rd_idx_ff;
	logic addr_ok;
	assign addr_ok = hsel && hready && htrans == fdchr_htrans_nonseq;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_ff <= 1'b0;
			rd_pend_ff <= 1'b0;
			wr_idx_ff <= fdchr_rst_byte;
			rd_idx_ff <= fdchr_rst_byte;
		end else begin
			wr_pend_ff <= addr_ok && hwrite;
			rd_pend_ff <= addr_ok && !hwrite;
			if (addr_ok) begin
				wr_idx_ff <= haddr[9:2];
				rd_idx_ff <= haddr[9:2];
			end
		end
	end

	logic [7:0] wbyte;
	assign wbyte = hwdata[7:0];
	function automatic logic wr_at(input logic p, input logic [7:0] i, input logic [7:0] k);
		wr_at = p && i == k;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// software control registers

	logic [1:0] alt_mode_ff; // only bit 1 is decoded: 00 and 01 normal, 10 and 11 alt mode two
	logic [1:0] tape_sel_ff;
	logic [1:0] last_drive_ff;
	logic [2:0] precomp_ff;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			motor_select_ff <= fdchr_rst_byte;
			last_drive_ff <= 2'h0;
		end else if (master_reset_pin) begin
			motor_select_ff <= fdchr_rst_byte;
		end else if (wr_at(wr_pend_ff, wr_idx_ff, fdchr_idx_motor)) begin
			motor_select_ff <= wbyte;
			last_drive_ff <= wbyte[1:0];
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			data_rate_ff <= 2'h0;
			precomp_ff <= 3'h0;
		end else if (wr_at(wr_pend_ff, wr_idx_ff, fdchr_idx_status)) begin
			data_rate_ff <= wbyte[1:0];
			precomp_ff <= wbyte[4:2];
		end else if (wr_at(wr_pend_ff, wr_idx_ff, fdchr_idx_input)) begin
			data_rate_ff <= wbyte[1:0];
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			tape_sel_ff <= 2'h0;
			alt_mode_ff <= 2'h0;
		end else begin
			if (wr_at(wr_pend_ff, wr_idx_ff, fdchr_idx_tape))
				tape_sel_ff <= wbyte[1:0];
			if (wr_at(wr_pend_ff, wr_idx_ff, fdchr_idx_mode))
				alt_mode_ff <= wbyte[1:0];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// pin edge toggles and latches

	logic wd_prev_ff;
	logic rd_prev_ff;
	logic wd_tog_ff;
	logic rd_tog_ff;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wd_prev_ff <= 1'b0;
			rd_prev_ff <= 1'b0;
			wd_tog_ff <= 1'b0;
			rd_tog_ff <= 1'b0;
		end else begin
			wd_prev_ff <= pins.write_bitstream_out;
			rd_prev_ff <= pins.read_data_in;
			if (pins.write_bitstream_out && !wd_prev_ff)
				wd_tog_ff <= !wd_tog_ff;
			if (pins.read_data_in && !rd_prev_ff)
				rd_tog_ff <= !rd_tog_ff;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// command phase state machine

	fdchr_state_t state_ff;
	logic [7:0] cmd_ff;
	logic [1:0] pcnt_ff;
	logic [7:0] cyl_ff [4];
	logic [1:0] cur_drv_ff;
	logic [7:0] res_ff [fdchr_dump_len];
	logic [3:0] res_cnt_ff;
	logic [3:0] res_idx_ff;
	logic lock_ff;
	logic implied_seek_en_ff;
	logic queue_disable_ff;
	logic poll_disable_ff;
	logic [3:0] queue_threshold_ff;
	logic [7:0] precomp_start_track_ff;
	logic [7:0] perp_ff;
	logic [7:0] steps_ff;
	logic [7:0] drive_status_three;
	logic fifo_wr;
	logic fifo_rd;
	logic rseek;

	assign fifo_wr = wr_at(wr_pend_ff, wr_idx_ff, fdchr_idx_fifo);
	// result bytes advance in the address phase so back to back reads never repeat a byte
	assign fifo_rd = wr_at(addr_ok && !hwrite, haddr[9:2], fdchr_idx_fifo);
	assign rseek = (cmd_ff & fdchr_cmd_rseek_m) == fdchr_cmd_rseek;
	assign drive_status_three = {1'b0, ~pins.write_protect_in, 1'b1, ~pins.track_zero_in,
		1'b1, wbyte[2:0]};

	function automatic logic [1:0] param_need(input logic [7:0] c);
		if (c == fdchr_cmd_seek || (c & fdchr_cmd_rseek_m) == fdchr_cmd_rseek)
			param_need = 2'd2;
		else if (c == fdchr_cmd_config)
			param_need = 2'd3;
		else
			param_need = 2'd1;
	endfunction

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_ff <= fdchr_idle;
			cmd_ff <= fdchr_rst_byte;
			pcnt_ff <= 2'h0;
			res_cnt_ff <= 4'h0;
			res_idx_ff <= 4'h0;
			for (int i = 0; i < fdchr_dump_len; i++)
				res_ff[i] <= fdchr_rst_byte;
			for (int i = 0; i < 4; i++)
				cyl_ff[i] <= fdchr_rst_byte;
			cur_drv_ff <= 2'h0;
			head_side_ff <= 1'b0;
			step_dir_ff <= 1'b0;
			step_out_ff <= 1'b0;
			lock_ff <= 1'b0;
			implied_seek_en_ff <= 1'b0;
			queue_disable_ff <= 1'b1;
			poll_disable_ff <= 1'b0;
			queue_threshold_ff <= fdchr_rst_thr;
			precomp_start_track_ff <= fdchr_rst_byte;
			perp_ff <= fdchr_rst_byte;
			steps_ff <= fdchr_rst_byte;
		end else begin
			step_out_ff <= 1'b0;
			unique case (state_ff)
				fdchr_idle: if (fifo_wr) begin
					cmd_ff <= wbyte;
					pcnt_ff <= 2'h0;
					res_idx_ff <= 4'h0;
					if (wbyte == fdchr_cmd_dump) begin
						for (int i = 0; i < 4; i++)
							res_ff[i] <= cyl_ff[i];
						res_ff[4] <= fdchr_rst_byte;
						res_ff[5] <= fdchr_rst_byte;
						res_ff[6] <= fdchr_rst_byte;
						res_ff[7] <= {lock_ff, perp_ff[6:0]};
						res_ff[8] <= {1'b0, implied_seek_en_ff, queue_disable_ff,
							poll_disable_ff, queue_threshold_ff};
						res_ff[9] <= precomp_start_track_ff;
						res_cnt_ff <= 4'(fdchr_dump_len);
						state_ff <= fdchr_result;
					end else if (wbyte[6:0] == fdchr_cmd_lock) begin
						lock_ff <= wbyte[7];
						res_ff[0] <= {3'h0, wbyte[7], 4'h0};
						res_cnt_ff <= 4'h1;
						state_ff <= fdchr_result;
					end else if (wbyte == fdchr_cmd_seek || wbyte == fdchr_cmd_sense
						|| wbyte == fdchr_cmd_config || wbyte == fdchr_cmd_perp
						|| (wbyte & fdchr_cmd_rseek_m) == fdchr_cmd_rseek) begin
						state_ff <= fdchr_param;
					end else begin
						res_ff[0] <= fdchr_st0_invalid;
						res_cnt_ff <= 4'h1;
						state_ff <= fdchr_result;
					end
				end
				fdchr_param: if (fifo_wr) begin
					pcnt_ff <= pcnt_ff + 2'h1;
					if (pcnt_ff == 2'h0 && cmd_ff != fdchr_cmd_config && cmd_ff != fdchr_cmd_perp) begin
						head_side_ff <= wbyte[2];
						cur_drv_ff <= wbyte[1:0];
					end
					if (cmd_ff == fdchr_cmd_perp)
						perp_ff <= wbyte;
					if (cmd_ff == fdchr_cmd_config && pcnt_ff == 2'h1) begin
						implied_seek_en_ff <= wbyte[6];
						queue_disable_ff <= wbyte[5];
						poll_disable_ff <= wbyte[4];
						queue_threshold_ff <= wbyte[3:0];
					end
					if (cmd_ff == fdchr_cmd_config && pcnt_ff == 2'h2)
						precomp_start_track_ff <= wbyte;
					if (cmd_ff == fdchr_cmd_seek && pcnt_ff == 2'h1) begin
						step_dir_ff <= wbyte > cyl_ff[cur_drv_ff];
						cyl_ff[cur_drv_ff] <= wbyte;
						steps_ff <= wbyte > cyl_ff[cur_drv_ff] ? wbyte - cyl_ff[cur_drv_ff]
							: cyl_ff[cur_drv_ff] - wbyte;
					end
					if (rseek && pcnt_ff == 2'h1) begin
						step_dir_ff <= cmd_ff[6];
						cyl_ff[cur_drv_ff] <= cmd_ff[6] ? cyl_ff[cur_drv_ff] + wbyte
							: cyl_ff[cur_drv_ff] - wbyte;
						steps_ff <= wbyte;
					end
					if (pcnt_ff == param_need(cmd_ff) - 2'h1 && cmd_ff == fdchr_cmd_sense) begin
						res_ff[0] <= drive_status_three;
						res_cnt_ff <= 4'h1;
						state_ff <= fdchr_result;
					end else if (pcnt_ff == param_need(cmd_ff) - 2'h1)
						state_ff <= cmd_ff == fdchr_cmd_seek || rseek ? fdchr_exec : fdchr_idle;
				end
				// one step pulse every other cycle until the head sits on the new cylinder
				fdchr_exec: if (step_out_ff == 1'b0 && steps_ff != 8'h00) begin
					step_out_ff <= 1'b1;
					steps_ff <= steps_ff - 8'h01;
				end else if (step_out_ff == 1'b0)
					state_ff <= fdchr_idle;
				fdchr_result: if (fifo_rd) begin
					res_idx_ff <= res_idx_ff + 4'h1;
					if (res_idx_ff == res_cnt_ff - 4'h1)
						state_ff <= fdchr_idle;
				end
				default: state_ff <= fdchr_idle;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// read multiplexer

	logic [7:0] mon_a;
	logic [7:0] mon_b;
	logic [7:0] tape_rd;
	logic [7:0] msr;
	logic [7:0] rd_byte;
	logic m2;
	logic [1:0] type_pair;
	logic step_latch_ff;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			step_latch_ff <= 1'b0;
		else if (step_out_ff)
			step_latch_ff <= 1'b1;
		else if (rd_pend_ff && rd_idx_ff == fdchr_idx_mon_a)
			step_latch_ff <= 1'b0;
	end

	assign m2 = alt_mode_ff[1];
	assign type_pair = cfg.ld0_config_f2[2*last_drive_ff +: 2];
	assign msr = {state_ff != fdchr_exec, state_ff == fdchr_result, 1'b0,
		state_ff != fdchr_idle, 4'h0};

	always_comb begin
		mon_a = m2 ? {pins.irq, pins.dma_request_out, ~step_latch_ff, ~pins.track_zero_in,
			head_side_ff ? 1'b0 : 1'b1, ~pins.index_in, ~pins.write_protect_in, ~step_dir_ff}
			: {pins.irq, pins.second_drive_absent, step_out_ff, pins.track_zero_in,
			head_side_ff, pins.index_in, pins.write_protect_in, step_dir_ff};
		mon_b = m2 ? {pins.second_drive_absent, ~(motor_select_ff[1:0] == 2'd1),
			~(motor_select_ff[1:0] == 2'd0), ~wd_tog_ff, ~rd_tog_ff, ~pins.write_gate_out,
			~(motor_select_ff[1:0] == 2'd3), ~(motor_select_ff[1:0] == 2'd2)}
			: {2'b11, motor_select_ff[0], wd_tog_ff, rd_tog_ff, ~pins.write_gate_out,
			motor_select_ff[5], motor_select_ff[4]};
		tape_rd = cfg.three_mode_enable ? {cfg.ld0_config_f1[4], cfg.ld0_config_f1[5],
			type_pair, cfg.ld0_config_f1[7], cfg.ld0_config_f1[6], tape_sel_ff}
			: {6'h0, tape_sel_ff};
		unique case (haddr[9:2])
			fdchr_idx_mon_a: rd_byte = mon_a;
			fdchr_idx_mon_b: rd_byte = mon_b;
			fdchr_idx_tape: rd_byte = tape_rd;
			fdchr_idx_status: rd_byte = msr;
			fdchr_idx_fifo: rd_byte = state_ff == fdchr_result ? res_ff[res_idx_ff] : 8'h00;
			fdchr_idx_input: rd_byte = {~pins.disk_change_in, 5'h1f, data_rate_ff};
			fdchr_idx_mode: rd_byte = {6'h0, alt_mode_ff};
			fdchr_idx_cfg: rd_byte = {lock_ff, precomp_ff, queue_threshold_ff};
			default: rd_byte = 8'h00;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h0;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			if (addr_ok && !hwrite)
				hrdata <= {24'h0, rd_byte};
			else
				hrdata <= 32'h0;
		end
	end
endmodule

// ==== sim/fdchr_drive_model.sv ====
// drive-side model: step counting head, pin levels set by the bench
// assumes the design pulses step_out_ff for one cycle per step
`timescale 1ns/1ps
module fdchr_drive_model import fdchr_pkg::*; (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic step_out_ff,
	input wire logic step_dir_ff,
	input wire logic [5:0] lv,
	output fdchr_pins_t pins
);
	logic [7:0] cyl_ff;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			cyl_ff <= 8'h00;
		else if (step_out_ff)
			cyl_ff <= step_dir_ff ? cyl_ff + 8'h01 : cyl_ff - 8'h01;
	end
	// irq, dma, second drive, track zero, index, protect, read data, then write bitstream, write gate and disk change held low
	// track zero pin is active low: it drops only while the head sits on cylinder zero
	assign pins = {lv[5:3], cyl_ff != 8'h00, lv[2:0], 3'b000};
endmodule

// ==== sim/fdchr_top_asserts.sv ====
// port-level checks of the host register block
// assumes zero wait ahb-lite slave, byte address is index times four
`timescale 1ns/1ps
module fdchr_top_asserts import fdchr_pkg::*; (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic master_reset_pin,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire fdchr_pins_t pins,
	input wire logic [7:0] motor_select_ff,
	input wire logic [1:0] data_rate_ff,
	input wire logic step_out_ff
);
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	logic wr_dp_ff;
	sequence s_acc(logic [31:0] a, logic w);
		hsel && hready && htrans == fdchr_htrans_nonseq && hwrite == w && haddr == a;
	endsequence
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			wr_dp_ff <= 1'b0;
		else
			wr_dp_ff <= hsel && hready && htrans == fdchr_htrans_nonseq && hwrite && haddr == 32'h8;
	end
	property p_okay; hreadyout && !hresp; endproperty
	property p_upper; hrdata[31:8] == 24'h0; endproperty
	property p_mr; master_reset_pin |=> motor_select_ff == 8'h00; endproperty
	property p_motor;
		s_acc(32'h8, 1'b1) ##1 !master_reset_pin |=> motor_select_ff == $past(hwdata[7:0]);
	endproperty
	property p_hold;
		$changed(motor_select_ff) |-> $past(wr_dp_ff) || $past(master_reset_pin);
	endproperty
	property p_rate;
		(s_acc(32'h10, 1'b1) or s_acc(32'h1c, 1'b1)) ##1 1'b1 |=> data_rate_ff == $past(hwdata[1:0]);
	endproperty
	property p_step; step_out_ff |=> !step_out_ff; endproperty
	property p_unmapped; s_acc(32'h18, 1'b0) |=> hrdata == 32'h0; endproperty
	property p_irq; s_acc(32'h0, 1'b0) |=> hrdata[7] == $past(pins.irq); endproperty
	a_okay: assert property (p_okay) else $error("bus answer not ready okay");
	a_upper: assert property (p_upper) else $error("upper read bits not zero");
	a_mr: assert property (p_mr) else $error("master reset left output control set");
	a_motor: assert property (p_motor) else $error("output control write lost");
	a_hold: assert property (p_hold) else $error("output control changed unprompted");
	a_rate: assert property (p_rate) else $error("rate not from last write");
	a_step: assert property (p_step) else $error("step pulse too long");
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	a_irq: assert property (p_irq) else $error("monitor a bit7 not interrupt");
endmodule
bind fdchr_top fdchr_top_asserts u_chk (.hclk, .hresetn, .master_reset_pin, .hsel, .haddr,
	.htrans, .hwrite, .hwdata, .hready, .hrdata, .hreadyout, .hresp, .pins, .motor_select_ff,
	.data_rate_ff, .step_out_ff);

// ==== sim/fdchr_tb_top.sv ====
// self-checking bench: ahb-lite register tasks and command sequences
// assumes the drive model and the bound checker
`timescale 1ns/1ps
module fdchr_tb_top import fdchr_pkg::*; ;
	logic hclk = 0, hresetn = 0, master_reset_pin = 0, hsel = 0, hwrite = 0;
	logic [31:0] haddr = '0, hwdata = '0, hrdata;
	logic [1:0] htrans = 2'b00, data_rate_ff;
	logic [2:0] hsize = fdchr_hsize_word;
	logic hready, hreadyout, hresp, step_out_ff, step_dir_ff, head_side_ff;
	logic [7:0] motor_select_ff, rd, tg;
	logic [5:0] lv = 6'h00;
	logic [7:0] ic[3] = '{8'h01, 8'h94, 8'h14};
	logic [7:0] ie[3] = '{8'h80, 8'h10, 8'h00};
	fdchr_pins_t pins;
	fdchr_cfg_t cfg = '0;
	int miscompares = 0, samples_checked = 0;
	assign hready = hreadyout;
	initial forever #2.5 hclk = ~hclk;
	fdchr_top uut (.hclk, .hresetn, .master_reset_pin, .hsel, .haddr, .htrans, .hwrite, .hsize,
		.hwdata, .hready, .hrdata, .hreadyout, .hresp, .pins, .cfg, .motor_select_ff,
		.data_rate_ff, .step_out_ff, .step_dir_ff, .head_side_ff);
	fdchr_drive_model u_drv (.hclk, .hresetn, .step_out_ff, .step_dir_ff, .lv, .pins);
	////////////////////////////////////////////////////////////////////////////////
	task automatic xf(input logic [7:0] idx, input logic w, input logic [7:0] wd,
		output logic [7:0] r);
		hsel <= 1'b1;
		htrans <= fdchr_htrans_nonseq;
		haddr <= {22'h0, idx, 2'b00};
		hwrite <= w;
		@(posedge hclk iff hready === 1'b1);
		htrans <= 2'b00;
		hwdata <= {24'h0, wd};
		@(posedge hclk iff hready === 1'b1);
		r = hrdata[7:0];
	endtask
	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		xf(idx, 1'b1, d, rd);
	endtask
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g,
		input logic [7:0] m);
		samples_checked++;
		if ((g & m) !== (e & m)) begin
			miscompares++;
			$display("unexpected %s expected %h seen %h", nm, e & m, g & m);
		end
	endtask
	task automatic rc(input logic [7:0] idx, input logic [7:0] e, input logic [7:0] m,
		input string nm);
		xf(idx, 1'b0, 8'h00, rd);
		chk(nm, e, rd, m);
	endtask
	task automatic cmd(input logic [7:0] b[$]);
		foreach (b[i]) wr(fdchr_idx_fifo, b[i]);
	endtask
	task automatic dump(input logic [7:0] e[10]);
		cmd('{fdchr_cmd_dump});
		for (int i = 0; i < 10; i++) rc(fdchr_idx_fifo, e[i], 8'hff, "dump byte");
	endtask
	task automatic idle();
		rd = 8'h00;
		for (int i = 0; i < 2000 && (rd & 8'hd0) !== 8'h80; i++) xf(fdchr_idx_status, 1'b0, 8'h00, rd);
		chk("main status", 8'h80, rd, 8'hd0);
	endtask
	task automatic test_done();
		$display("comparisons %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		for (int i = 0; i < 3; i++) begin
			cmd('{ic[i]});
			rc(fdchr_idx_fifo, ie[i], 8'hff, "result");
			rc(fdchr_idx_fifo, 8'h00, 8'hff, "extra result");
		end
		cmd('{fdchr_cmd_sense, 8'h05});
		rc(fdchr_idx_fifo, 8'h05, 8'h07, "drive status");
		rc(fdchr_idx_fifo, 8'h00, 8'hff, "extra result");
		dump('{0, 0, 0, 0, 0, 0, 0, 0, 8'h20, 0});
		cmd('{fdchr_cmd_config, 8'h00, 8'h4a, 8'h33});
		cmd('{fdchr_cmd_perp, 8'h03});
		cmd('{8'h94});
		rc(fdchr_idx_fifo, 8'h10, 8'hff, "lock result");
		cmd('{fdchr_cmd_seek, 8'h05, 8'h25});
		idle();
		chk("step dir", 8'h01, {7'h0, step_dir_ff}, 8'h01);
		chk("head side", 8'h01, {7'h0, head_side_ff}, 8'h01);
		cmd('{8'hcf, 8'h05, 8'h03});
		idle();
		dump('{0, 8'h28, 0, 0, 0, 0, 0, 8'h83, 8'h4a, 8'h33});
		cmd('{fdchr_cmd_rseek, 8'h05, 8'h08});
		idle();
		dump('{0, 8'h20, 0, 0, 0, 0, 0, 8'h83, 8'h4a, 8'h33});
		chk("step dir", 8'h00, {7'h0, step_dir_ff}, 8'h01);
		cfg <= '{1'b1, 8'hf0, 8'h08};
		wr(fdchr_idx_motor, 8'h15);
		@(posedge hclk);
		chk("output control", 8'h15, motor_select_ff, 8'hff);
		wr(fdchr_idx_tape, 8'h02);
		rc(fdchr_idx_tape, 8'hee, 8'hff, "tape assign");
		wr(fdchr_idx_motor, 8'h16);
		rc(fdchr_idx_tape, 8'hce, 8'hff, "tape assign");
		cfg <= '{1'b0, 8'hf0, 8'h08};
		wr(fdchr_idx_motor, 8'h15);
		rc(fdchr_idx_tape, 8'h02, 8'hff, "tape assign");
		for (int i = 0; i < 2; i++) begin
			lv <= i ? 6'h15 : 6'h2a;
			wr(fdchr_idx_mode, 8'h00);
			rc(fdchr_idx_mon_a, {lv[5], lv[3], 3'b011, lv[2:1], 1'b0}, 8'hff,
				"monitor a");
			rc(fdchr_idx_mon_b, 8'h25, 8'h27, "monitor b");
			wr(fdchr_idx_mode, 8'h02);
			rc(fdchr_idx_mon_a, {lv[5:4], 3'b100, ~lv[2:1], 1'b1}, 8'hff,
				"monitor a");
			rc(fdchr_idx_mon_b, {lv[3], 7'h23}, 8'he3, "monitor b");
		end
		lv <= 6'h00;
		wr(fdchr_idx_mode, 8'h00);
		xf(fdchr_idx_mon_b, 1'b0, 8'h00, tg);
		lv <= 6'h01;
		repeat (4) @(posedge hclk);
		lv <= 6'h00;
		repeat (4) @(posedge hclk);
		rc(fdchr_idx_mon_b, ~tg, 8'h08, "read toggle");
		wr(fdchr_idx_status, 8'h02);
		wr(fdchr_idx_input, 8'h01);
		@(posedge hclk);
		chk("data rate", 8'h01, {6'h0, data_rate_ff}, 8'h03);
		wr(fdchr_idx_input, 8'h03);
		wr(fdchr_idx_status, 8'h00);
		@(posedge hclk);
		chk("data rate", 8'h00, {6'h0, data_rate_ff}, 8'h03);
		wr(8'h06, 8'h5a);
		rc(8'h06, 8'h00, 8'hff, "unmapped");
		master_reset_pin <= 1'b1;
		@(posedge hclk);
		master_reset_pin <= 1'b0;
		@(posedge hclk);
		chk("output control", 8'h00, motor_select_ff, 8'hff);
		test_done();
	end
	initial begin
		#100000;
		miscompares++;
		test_done();
	end
endmodule
